// File: fault_mode_supervisor.sv
// fault, watchdog, low-power and clock-source supervisor
`include "fault_mode_supervisor_map.svh"
`timescale 1ns/1ps
module fault_mode_supervisor #(
    parameter int unsigned CYCLES_PER_MS = `MS_CYCLES,
    parameter int unsigned MONITOR_ADDR_W = 12,
    parameter int unsigned MONITOR_VARS = 16,
    parameter int unsigned FREQ_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // die temperature comparators
    input wire logic overtemp_trip,
    input wire logic overtemp_below_hys,
    // driver disable and tickle pins
    input wire logic driver_disable_in,
    input wire logic tickle_pin,
    // command and configuration bits
    input wire logic clear_errors_cmd,
    input wire logic low_power_select,
    input wire logic zero_speed_cmd,
    input wire logic [1:0] speed_mode,
    input wire logic [1:0] ref_profile_cfg,
    input wire logic [6:0] duty_hysteresis,
    input wire logic [FREQ_W-1:0] input_max_freq,
    input wire logic [FREQ_W-1:0] speed_input_freq,
    input wire logic tickle_monitor_en,
    input wire logic tickle_bus_write,
    input wire logic tickle_error_action,
    input wire logic tickle_source_select,
    input wire logic [1:0] tickle_timeout_select,
    input wire logic monitor_dac_en,
    input wire logic [MONITOR_ADDR_W-1:0] monitor_variable_addr,
    input wire logic [MONITOR_VARS*12-1:0] monitor_vars,
    input wire logic [1:0] clock_select,
    input wire logic reference_clock_en,
    input wire logic [7:0] reference_clock_freq_cfg,
    // power stage and supply controls
    output logic switches_hiz,
    output logic charge_pump_en,
    output logic regulators_en,
    output logic sense_amp_en,
    output logic serial_bus_en,
    output logic fault_out_n,
    // status flags
    output logic driver_fault_flag,
    output logic overtemp_flag,
    output logic thermal_shutdown_sticky,
    output logic watchdog_fault_flag,
    output logic [1:0] power_state,
    output logic standby_freq_low,
    // monitor and clock source
    output logic [11:0] monitor_analog_out,
    output logic monitor_out_en,
    output logic osc_calibrate_en,
    output logic [7:0] osc_ref_freq_cfg
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] disable_sync_reg;
    logic [1:0] tickle_sync_reg;
    logic tickle_prev_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            disable_sync_reg <= 2'h0;
            tickle_sync_reg <= 2'h0;
            tickle_prev_reg <= 1'b0;
        end else begin
            disable_sync_reg <= {disable_sync_reg[0], driver_disable_in};
            tickle_sync_reg <= {tickle_sync_reg[0], tickle_pin};
            tickle_prev_reg <= tickle_sync_reg[1];
        end
    end

    // ==========================================================
    // watchdog tickles and timer
    tickle_if tk ();
    logic tickle_rise;
    logic en_prev_reg;
    assign tickle_rise = tickle_sync_reg[1] & ~tickle_prev_reg;
    assign tk.enable = tickle_monitor_en & en_prev_reg;
    assign tk.use_bus = tickle_source_select;
    assign tk.timeout_sel = tickle_timeout_select;
    assign tk.tickle = tickle_source_select ? tickle_bus_write : tickle_rise;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_prev_reg <= 1'b0;
        end else begin
            en_prev_reg <= tickle_monitor_en;
        end
    end

    tickle_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .tk(tk)
    );

    // ==========================================================
    // thermal shutdown, always armed
    logic tsd_active_reg;
    logic tsd_sticky_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tsd_active_reg <= 1'b0;
        end else if (overtemp_trip) begin
            tsd_active_reg <= 1'b1;
        end else if (overtemp_below_hys) begin
            tsd_active_reg <= 1'b0;
        end
    end

    // a trip wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tsd_sticky_reg <= 1'b0;
        end else if (overtemp_trip) begin
            tsd_sticky_reg <= 1'b1;
        end else if (clear_errors_cmd) begin
            tsd_sticky_reg <= 1'b0;
        end
    end

    // ==========================================================
    // watchdog fault flag and latch
    logic wd_flag_reg;
    logic wd_latch_reg;
    // an expiry wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wd_flag_reg <= 1'b0;
        end else if (tk.expired) begin
            wd_flag_reg <= 1'b1;
        end else if (clear_errors_cmd) begin
            wd_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wd_latch_reg <= 1'b0;
        end else if (tk.expired && tickle_error_action) begin
            wd_latch_reg <= 1'b1;
        end else if (clear_errors_cmd) begin
            wd_latch_reg <= 1'b0;
        end
    end

    // ==========================================================
    // standby threshold for frequency input
    logic [FREQ_W+6:0] scaled_freq;
    logic [FREQ_W-1:0] standby_thr;
    logic [6:0] hys_pct;
    always_comb begin
        hys_pct = (duty_hysteresis < 7'h1) ? 7'h1 : duty_hysteresis;
        scaled_freq = (FREQ_W+7)'((input_max_freq * hys_pct) / `PERCENT_SCALE);
        if (ref_profile_cfg != `REF_PROFILE_DEFAULT) begin
            standby_thr = FREQ_W'(`STANDBY_MIN_FREQ_HZ);
        end else if (scaled_freq < (FREQ_W+7)'(`STANDBY_MIN_FREQ_HZ)) begin
            standby_thr = FREQ_W'(`STANDBY_MIN_FREQ_HZ);
        end else begin
            standby_thr = FREQ_W'(scaled_freq);
        end
    end

    logic standby_low_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            standby_low_reg <= 1'b0;
        end else begin
            standby_low_reg <= (speed_mode == `SPEED_MODE_FREQUENCY) &&
                (speed_input_freq < standby_thr);
        end
    end
    assign standby_freq_low = standby_low_reg;

    // ==========================================================
    // low-power state
    fault_mode_supervisor_pkg::power_state_e pwr_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_reg <= fault_mode_supervisor_pkg::PWR_RUN;
        end else begin
            case (pwr_reg)
                fault_mode_supervisor_pkg::PWR_RUN: begin
                    if (zero_speed_cmd && low_power_select) begin
                        pwr_reg <= fault_mode_supervisor_pkg::PWR_SLEEP;
                    end else if (zero_speed_cmd) begin
                        pwr_reg <= fault_mode_supervisor_pkg::PWR_STANDBY;
                    end
                end
                default: begin
                    if (!zero_speed_cmd) begin
                        pwr_reg <= fault_mode_supervisor_pkg::PWR_RUN;
                    end
                end
            endcase
        end
    end
    assign power_state = pwr_reg;

    // ==========================================================
    // power stage and supply outputs
    logic sleeping;
    logic hiz_next;
    // standby and sleep keep the switches off as well
    assign sleeping = (pwr_reg == fault_mode_supervisor_pkg::PWR_SLEEP);
    assign hiz_next = tsd_active_reg | wd_latch_reg | disable_sync_reg[1] |
        (pwr_reg != fault_mode_supervisor_pkg::PWR_RUN);

    logic hiz_reg;
    logic pump_reg;
    logic fault_n_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hiz_reg <= 1'b1;
            pump_reg <= 1'b0;
            fault_n_reg <= 1'b1;
        end else begin
            hiz_reg <= hiz_next;
            pump_reg <= ~tsd_active_reg & ~sleeping;
            fault_n_reg <= ~(tsd_active_reg | wd_flag_reg);
        end
    end
    assign switches_hiz = hiz_reg;
    assign charge_pump_en = pump_reg;
    assign regulators_en = ~sleeping;
    assign sense_amp_en = ~sleeping;
    assign serial_bus_en = ~sleeping;
    assign fault_out_n = fault_n_reg;

    // ==========================================================
    // status flags
    assign driver_fault_flag = tsd_active_reg | wd_latch_reg;
    assign overtemp_flag = tsd_active_reg;
    assign thermal_shutdown_sticky = tsd_sticky_reg;
    assign watchdog_fault_flag = wd_flag_reg;

    // ==========================================================
    // monitor output
    logic [11:0] mon_reg;
    logic mon_en_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mon_reg <= 12'h000;
            mon_en_reg <= 1'b0;
        end else begin
            mon_en_reg <= monitor_dac_en;
            if (!monitor_dac_en) begin
                mon_reg <= 12'h000;
            end else if (monitor_variable_addr < MONITOR_ADDR_W'(MONITOR_VARS)) begin
                mon_reg <= monitor_vars[monitor_variable_addr*12 +: 12];
            end else begin
                mon_reg <= 12'h000;
            end
        end
    end
    assign monitor_analog_out = mon_reg;
    assign monitor_out_en = mon_en_reg;

    // ==========================================================
    // clock source; internal oscillator from reset
    logic cal_reg;
    logic [7:0] ref_cfg_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cal_reg <= 1'b0;
            ref_cfg_reg <= 8'h00;
        end else begin
            cal_reg <= (clock_select == `CLOCK_SELECT_EXTERNAL) && reference_clock_en;
            ref_cfg_reg <= reference_clock_freq_cfg;
        end
    end
    assign osc_calibrate_en = cal_reg;
    assign osc_ref_freq_cfg = ref_cfg_reg;
endmodule : fault_mode_supervisor

// File: fault_mode_supervisor_map.svh
// field codes and timing counts of the fault and mode supervisor
`ifndef FAULT_MODE_SUPERVISOR_MAP_SVH
`define FAULT_MODE_SUPERVISOR_MAP_SVH

// ==========================================================
// clock and timing
`define CORE_CLK_HZ 40000000
`define TICKLE_PIN_TIMEOUT_0_MS 100
`define TICKLE_PIN_TIMEOUT_1_MS 200
`define TICKLE_PIN_TIMEOUT_2_MS 500
`define TICKLE_PIN_TIMEOUT_3_MS 1000
`define TICKLE_BUS_TIMEOUT_0_S 1
`define TICKLE_BUS_TIMEOUT_1_S 2
`define TICKLE_BUS_TIMEOUT_2_S 5
`define TICKLE_BUS_TIMEOUT_3_S 10
`define MS_CYCLES (`CORE_CLK_HZ / 1000)
`define STANDBY_MIN_FREQ_HZ 3

// ==========================================================
// field codes
`define CLOCK_SELECT_EXTERNAL 2'h3
`define SPEED_MODE_FREQUENCY 2'h3
`define REF_PROFILE_DEFAULT 2'h0
`define PERCENT_SCALE 100

`endif

// File: fault_mode_supervisor_pkg.sv
// types shared by the fault and mode supervisor
package fault_mode_supervisor_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STANDBY,
        PWR_SLEEP
    } power_state_e;
endpackage : fault_mode_supervisor_pkg

// File: tickle_if.sv
// tickle timer hookup between supervisor and watchdog timer
`timescale 1ns/1ps
interface tickle_if;
    logic enable;
    logic use_bus;
    logic [1:0] timeout_sel;
    logic tickle;
    logic expired;
    modport sup (output enable, output use_bus, output timeout_sel, output tickle, input expired);
    modport tmr (input enable, input use_bus, input timeout_sel, input tickle, output expired);
endinterface : tickle_if

// File: tickle_timer.sv
// watchdog interval timer with selectable timeout
`include "fault_mode_supervisor_map.svh"
`timescale 1ns/1ps
module tickle_timer #(
    parameter int unsigned CYCLES_PER_MS = `MS_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // supervisor side
    tickle_if.tmr tk
);
    // ==========================================================
    // timeout lookup
    function automatic logic [38:0] limit_of(input logic use_bus, input logic [1:0] sel);
        logic [31:0] ms;
        ms = 32'h0;
        case ({use_bus, sel})
            3'h0: ms = `TICKLE_PIN_TIMEOUT_0_MS;
            3'h1: ms = `TICKLE_PIN_TIMEOUT_1_MS;
            3'h2: ms = `TICKLE_PIN_TIMEOUT_2_MS;
            3'h3: ms = `TICKLE_PIN_TIMEOUT_3_MS;
            3'h4: ms = `TICKLE_BUS_TIMEOUT_0_S * 1000;
            3'h5: ms = `TICKLE_BUS_TIMEOUT_1_S * 1000;
            3'h6: ms = `TICKLE_BUS_TIMEOUT_2_S * 1000;
            default: ms = `TICKLE_BUS_TIMEOUT_3_S * 1000;
        endcase
        limit_of = 39'(64'(ms) * 64'(CYCLES_PER_MS));
    endfunction : limit_of

    // ==========================================================
    // interval counter
    logic [38:0] count_reg;
    logic expired_reg;
    logic [38:0] limit;
    assign limit = limit_of(tk.use_bus, tk.timeout_sel);
    assign tk.expired = expired_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= 39'h0;
            expired_reg <= 1'b0;
        end else if (!tk.enable) begin
            count_reg <= 39'h0;
            expired_reg <= 1'b0;
        end else if (tk.tickle) begin
            count_reg <= 39'h0;
            expired_reg <= 1'b0;
        end else if (count_reg >= limit) begin
            expired_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + 39'h1;
            expired_reg <= 1'b0;
        end
    end
endmodule : tickle_timer

// File: fault_mode_supervisor_sva.sv
// port checker for the fault and mode supervisor
`timescale 1ns/1ps
module fault_mode_supervisor_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // inputs
    input wire logic overtemp_trip,
    input wire logic driver_disable_in,
    input wire logic clear_errors_cmd,
    input wire logic low_power_select,
    input wire logic zero_speed_cmd,
    input wire logic [1:0] clock_select,
    input wire logic reference_clock_en,
    // outputs
    input wire logic switches_hiz,
    input wire logic charge_pump_en,
    input wire logic regulators_en,
    input wire logic sense_amp_en,
    input wire logic serial_bus_en,
    input wire logic fault_out_n,
    input wire logic driver_fault_flag,
    input wire logic overtemp_flag,
    input wire logic thermal_shutdown_sticky,
    input wire logic watchdog_fault_flag,
    input wire logic [1:0] power_state,
    input wire logic osc_calibrate_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // assertions
    thermal_flags_a:
        assert property (overtemp_trip |=> overtemp_flag && driver_fault_flag
            && thermal_shutdown_sticky) else $error("thermal flags missing");
    thermal_off_a:
        assert property (overtemp_trip |-> ##2 switches_hiz && !charge_pump_en && !fault_out_n)
            else $error("thermal shutdown outputs wrong");
    sticky_hold_a:
        assert property (thermal_shutdown_sticky && !clear_errors_cmd |=> thermal_shutdown_sticky)
            else $error("thermal sticky dropped");
    sleep_entry_a:
        assert property (power_state == fault_mode_supervisor_pkg::PWR_RUN &&
            zero_speed_cmd && low_power_select |=>
            power_state == fault_mode_supervisor_pkg::PWR_SLEEP) else $error("no sleep");
    sleep_supply_a:
        assert property (power_state == fault_mode_supervisor_pkg::PWR_SLEEP |->
            !regulators_en && !sense_amp_en && !serial_bus_en) else $error("sleep supplies on");
    standby_supply_a:
        assert property (power_state == fault_mode_supervisor_pkg::PWR_STANDBY |->
            regulators_en && serial_bus_en) else $error("standby supplies off");
    drv_off_hiz_a:
        assert property (driver_disable_in [*3] |=> switches_hiz) else $error("switches driven");
    wd_flag_hold_a:
        assert property (watchdog_fault_flag && !clear_errors_cmd |=> watchdog_fault_flag)
            else $error("watchdog flag dropped");
    cal_select_a:
        assert property (1'b1 |=> osc_calibrate_en == ($past(clock_select) == 2'h3
            && $past(reference_clock_en))) else $error("calibrate enable wrong");
    // ==========================================
    // covers
    thermal_c: cover property (overtemp_trip ##2 !fault_out_n);
    wd_c: cover property ($rose(watchdog_fault_flag));
    sleep_c: cover property (power_state == fault_mode_supervisor_pkg::PWR_SLEEP);
endmodule : fault_mode_supervisor_sva

// File: mcu_model.sv
// controller model issuing watchdog tickles on the pin or the bus
`timescale 1ns/1ps
module mcu_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // tickle control
    input wire logic run,
    input wire logic on_bus,
    input wire logic [15:0] period,
    // tickles
    output logic tickle_pin,
    output logic tickle_bus_write
);
    logic [15:0] cnt_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 16'h0000;
            tickle_pin <= 1'b0;
            tickle_bus_write <= 1'b0;
        end else begin
            cnt_reg <= (run && cnt_reg + 16'h0001 < period) ? cnt_reg + 16'h0001 : 16'h0000;
            tickle_bus_write <= run && on_bus && cnt_reg == 16'h0000;
            tickle_pin <= run && !on_bus && cnt_reg < (period >> 1);
        end
    end
endmodule : mcu_model

// File: fault_mode_supervisor_tb.sv
// self-checking bench for the fault and mode supervisor
`include "fault_mode_supervisor_map.svh"
`timescale 1ns/1ps
bind fault_mode_supervisor fault_mode_supervisor_sva u_sva (.core_clk, .rstn, .overtemp_trip,
    .driver_disable_in, .clear_errors_cmd, .low_power_select, .zero_speed_cmd, .clock_select,
    .reference_clock_en, .switches_hiz, .charge_pump_en, .regulators_en, .sense_amp_en,
    .serial_bus_en, .fault_out_n, .driver_fault_flag, .overtemp_flag, .thermal_shutdown_sticky,
    .watchdog_fault_flag, .power_state, .osc_calibrate_en);
module fault_mode_supervisor_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic overtemp_trip, overtemp_below_hys, driver_disable_in, clear_errors_cmd;
    logic low_power_select, zero_speed_cmd, tickle_monitor_en, tickle_error_action;
    logic tickle_source_select, monitor_dac_en, reference_clock_en, mcu_run, mcu_bus;
    logic [1:0] speed_mode, ref_profile_cfg, tickle_timeout_select, clock_select, power_state;
    logic [6:0] duty_hysteresis;
    logic [15:0] input_max_freq, speed_input_freq, mcu_period;
    logic [11:0] monitor_variable_addr, monitor_analog_out;
    logic [191:0] monitor_vars;
    logic [7:0] reference_clock_freq_cfg, osc_ref_freq_cfg;
    logic switches_hiz, charge_pump_en, regulators_en, sense_amp_en, serial_bus_en;
    logic fault_out_n, driver_fault_flag, overtemp_flag, thermal_shutdown_sticky;
    logic watchdog_fault_flag, standby_freq_low, monitor_out_en, osc_calibrate_en;
    logic tickle_pin, tickle_bus_write;
    int error_cnt = 0;
    int n_checks = 0;
    int lim_t[8] = '{`TICKLE_PIN_TIMEOUT_0_MS, `TICKLE_PIN_TIMEOUT_1_MS,
        `TICKLE_PIN_TIMEOUT_2_MS, `TICKLE_PIN_TIMEOUT_3_MS, `TICKLE_BUS_TIMEOUT_0_S * 1000,
        `TICKLE_BUS_TIMEOUT_1_S * 1000, `TICKLE_BUS_TIMEOUT_2_S * 1000,
        `TICKLE_BUS_TIMEOUT_3_S * 1000};
    int f_t[6] = '{2, 4, 99, 101, 2, 4};
    int thr_t[6] = '{3, 3, 100, 100, 3, 3};
    always #12.5 core_clk = ~core_clk;
    fault_mode_supervisor #(.CYCLES_PER_MS(1)) u_dut (.core_clk, .rstn, .overtemp_trip,
        .overtemp_below_hys, .driver_disable_in, .tickle_pin, .clear_errors_cmd,
        .low_power_select, .zero_speed_cmd, .speed_mode, .ref_profile_cfg, .duty_hysteresis,
        .input_max_freq, .speed_input_freq, .tickle_monitor_en, .tickle_bus_write,
        .tickle_error_action, .tickle_source_select, .tickle_timeout_select, .monitor_dac_en,
        .monitor_variable_addr, .monitor_vars, .clock_select, .reference_clock_en,
        .reference_clock_freq_cfg, .switches_hiz, .charge_pump_en, .regulators_en,
        .sense_amp_en, .serial_bus_en, .fault_out_n, .driver_fault_flag, .overtemp_flag,
        .thermal_shutdown_sticky, .watchdog_fault_flag, .power_state, .standby_freq_low,
        .monitor_analog_out, .monitor_out_en, .osc_calibrate_en, .osc_ref_freq_cfg);
    mcu_model u_mcu (.core_clk, .rstn, .run(mcu_run), .on_bus(mcu_bus), .period(mcu_period),
        .tickle_pin, .tickle_bus_write);
    // ==========================================
    // tasks
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic drive(input logic trip, input logic zero, input logic lps, input logic off);
        @(posedge core_clk);
        overtemp_trip <= trip;
        overtemp_below_hys <= !trip;
        zero_speed_cmd <= zero;
        low_power_select <= lps;
        driver_disable_in <= off;
        cyc(5);
    endtask : drive
    task automatic clr;
        @(posedge core_clk);
        clear_errors_cmd <= 1'b1;
        @(posedge core_clk);
        clear_errors_cmd <= 1'b0;
    endtask : clr
    task automatic wd_setup(input logic bus, input logic [1:0] sel, input logic act);
        @(posedge core_clk);
        tickle_monitor_en <= 1'b0;
        clr();
        tickle_source_select <= bus;
        tickle_timeout_select <= sel;
        tickle_error_action <= act;
        @(posedge core_clk);
        tickle_monitor_en <= 1'b1;
    endtask : wd_setup
    task automatic wd_tickle(input logic src, input logic mb, input logic [15:0] p, input logic e);
        wd_setup(src, 2'h0, 1'b1);
        mcu_bus <= mb;
        mcu_period <= p;
        mcu_run <= 1'b1;
        cyc(3000);
        chk("tickled watchdog flag", {15'h0000, e}, watchdog_fault_flag);
        @(posedge core_clk);
        mcu_run <= 1'b0;
    endtask : wd_tickle
    // ==========================================
    // sequence
    initial begin
        int n;
        {overtemp_trip, driver_disable_in, clear_errors_cmd, low_power_select} = 4'h0;
        {zero_speed_cmd, tickle_monitor_en, tickle_error_action, tickle_source_select} = 4'h0;
        {monitor_dac_en, mcu_run, mcu_bus, overtemp_below_hys, reference_clock_en} = 5'h03;
        {speed_mode, ref_profile_cfg, tickle_timeout_select, clock_select} = 8'hc3;
        {duty_hysteresis, input_max_freq, speed_input_freq} = 39'h0;
        {monitor_variable_addr, mcu_period, reference_clock_freq_cfg} = 36'h00003c5a;
        for (int i = 0; i < 16; i++) monitor_vars[12*i+:12] = 12'h100 + 12'(i);
        @(posedge core_clk);
        #1;
        chk("calibrate in reset", 16'h0000, osc_calibrate_en);
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        cyc(3);
        chk("ref freq cfg", 16'h005a, osc_ref_freq_cfg);
        for (int j = 0; j < 3; j++) begin
            @(posedge core_clk);
            clock_select <= (j == 2) ? 2'h2 : 2'h3;
            reference_clock_en <= (j != 1);
            cyc(3);
            chk("calibrate", {15'h0000, j == 0}, osc_calibrate_en);
        end
        drive(1'b1, 1'b0, 1'b0, 1'b0);
        chk("overtemp flags", 16'h0111, {overtemp_flag, 3'h0, driver_fault_flag, 3'h0,
            thermal_shutdown_sticky});
        chk("thermal outputs", 16'h0100, {switches_hiz, 3'h0, charge_pump_en, 3'h0,
            fault_out_n});
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        chk("recovered outputs", 16'h0011, {switches_hiz, 3'h0, charge_pump_en, 3'h0,
            fault_out_n});
        chk("sticky kept", 16'h0001, thermal_shutdown_sticky);
        clr();
        cyc(2);
        chk("sticky cleared", 16'h0000, thermal_shutdown_sticky);
        drive(1'b0, 1'b1, 1'b1, 1'b0);
        chk("sleep state", fault_mode_supervisor_pkg::PWR_SLEEP, power_state);
        chk("sleep supplies", 16'h0001, {regulators_en, sense_amp_en, serial_bus_en,
            charge_pump_en, switches_hiz});
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        chk("run state", fault_mode_supervisor_pkg::PWR_RUN, power_state);
        drive(1'b0, 1'b1, 1'b0, 1'b0);
        chk("standby state", fault_mode_supervisor_pkg::PWR_STANDBY, power_state);
        chk("standby supplies", 16'h0007, {regulators_en, serial_bus_en, charge_pump_en});
        drive(1'b0, 1'b0, 1'b0, 1'b1);
        chk("disabled switches", 16'h0001, switches_hiz);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        chk("enabled switches", 16'h0000, switches_hiz);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            ref_profile_cfg <= (k > 3) ? 2'h1 : 2'h0;
            duty_hysteresis <= (k > 1) ? 7'h0a : 7'h01;
            input_max_freq <= (k > 1) ? 16'h03e8 : 16'h0064;
            speed_input_freq <= 16'(f_t[k]);
            cyc(3);
            chk("standby freq", {15'h0000, f_t[k] < thr_t[k]}, standby_freq_low);
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            monitor_dac_en <= (m != 2);
            monitor_variable_addr <= (m == 0) ? 12'h005 : 12'h00f;
            cyc(3);
            chk("monitor enable", {15'h0000, m != 2}, monitor_out_en);
            if (m != 2) begin
                chk("monitor value", (m == 0) ? 16'h0105 : 16'h010f, monitor_analog_out);
            end
        end
        wd_tickle(1'b0, 1'b0, 16'h003c, 1'b0);
        wd_tickle(1'b0, 1'b0, 16'h0096, 1'b1);
        wd_tickle(1'b1, 1'b1, 16'h0258, 1'b0);
        wd_tickle(1'b1, 1'b0, 16'h003c, 1'b1);
        wd_tickle(1'b0, 1'b1, 16'h003c, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wd_setup(i[2], i[1:0], i[0]);
            n = 0;
            while (watchdog_fault_flag !== 1'b1) begin
                cyc(1);
                n++;
                if (n > 11000) begin
                    chk("watchdog wait", 16'h0001, 16'h0000);
                    test_done();
                end
            end
            chk("expiry window", 16'h0001,
                {15'h0000, n >= lim_t[i] && n <= lim_t[i] + 6});
            cyc(2);
            chk("latched hiz", {15'h0000, i[0]}, switches_hiz);
            chk("watchdog fault pin", 16'h0000, fault_out_n);
        end
        test_done();
    end
endmodule : fault_mode_supervisor_tb
